//--- ddc_clk_div.v
`timescale 1ns/100ps
module ddc_clk_div #(
    parameter DIV = 1
) (
    // clock, reset, enable
    input  wire       ref_clk_in,
    input  wire       rst_n_in,
    input  wire       clk_en_in,
    // memory clock
    output reg        mem_clk_out,
    output wire       fall_tick_out
);
    reg [7:0] cnt_q;

    // tick in the cycle before the memory clock falls: commands change then
    assign fall_tick_out = mem_clk_out && (cnt_q == DIV[7:0] - 8'h01);

    always @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q       <= 8'h00;
            mem_clk_out <= 1'b0;
        end else if (clk_en_in) begin
            if (cnt_q == DIV[7:0] - 8'h01) begin
                cnt_q       <= 8'h00;
                mem_clk_out <= !mem_clk_out;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
endmodule

//--- ddc_cmd_check.v
`timescale 1ns/100ps
`include "ddc_regs.vh"
module ddc_cmd_check (
    // requested command
    input  wire [3:0]  code_in,
    input  wire [14:0] addr_in,
    // controller state
    input  wire [3:0]  open_banks_in,
    input  wire        burst_in,
    input  wire        bst_ok_in,
    input  wire        read_ok_in,
    input  wire        in_sref_in,
    // verdict
    output reg         legal_out
);
    wire [1:0] bank    = {addr_in[`DDC_ADDR_BS1_BIT], addr_in[`DDC_ADDR_BS0_BIT]};
    wire [5:0] op_mode = addr_in[12:7];
    wire       idle    = (open_banks_in == 4'h0) && !burst_in;
    wire       base_ok = ((op_mode == `DDC_OPMODE_NORMAL) || (op_mode == `DDC_OPMODE_DLLRST)) &&
                         ((addr_in[2:0] == `DDC_BL_2) || (addr_in[2:0] == `DDC_BL_4) ||
                          (addr_in[2:0] == `DDC_BL_8)) &&
                         ((addr_in[6:4] == `DDC_CL_2) || (addr_in[6:4] == `DDC_CL_2P5));

    always @* begin
        legal_out = 1'b0;
        if (in_sref_in) begin
            legal_out = (code_in == `DDC_CMD_SREF_OUT);
        end else begin
            case (code_in)
                `DDC_CMD_NOP:      legal_out = 1'b1;
                `DDC_CMD_ACT:      legal_out = !open_banks_in[bank];
                `DDC_CMD_RD:       legal_out = open_banks_in[bank] && read_ok_in;
                `DDC_CMD_WR:       legal_out = open_banks_in[bank];
                `DDC_CMD_BST:      legal_out = bst_ok_in;
                `DDC_CMD_PRE:      legal_out = !burst_in;
                `DDC_CMD_REF:      legal_out = idle;
                `DDC_CMD_SREF_IN:  legal_out = idle;
                // base needs normal or dll-reset mode; ext only with bank code 01
                `DDC_CMD_LOAD:     legal_out = idle && ((bank == 2'h0) ? base_ok :
                                               (bank == 2'h1));
                default:           legal_out = 1'b0;
            endcase
        end
    end
endmodule

//--- ddc_ctrl.v
// Operation
// - base load with operating-mode bits zero selects normal mode; low seven bits set burst and latency
// - base load with only the dll reset bit set starts a dll reset
// - a dll-reset load should be followed by a normal-mode load; controller does not enforce this, it only flags need_norm_q in status
// - controller never programs reserved or test operating-mode codes
// - after enabling the dll, a base load resetting the dll is needed; controller refuses reads until one is issued
// - extended load only when banks idle and no burst; then wait before next command
// - after dll enable, 200 clocks with clock enable high before any read
// - burst terminate ends only reads without auto precharge
// - all strobes low loads a mode register chosen by the bank selects
// - write mask low writes the element, high suppresses it
// - clock enable high except self refresh; no undefined input combinations
`timescale 1ns/100ps
`include "ddc_regs.vh"
module ddc_ctrl #(
    parameter CLK_DIV  = 1,
    parameter ADDR_W   = 13
) (
    // clock, reset, enable
    input  wire              ref_clk_in,
    input  wire              reset_n_in,
    input  wire              clk_en_in,
    // software register port
    input  wire [4:0]        reg_addr_in,
    input  wire [31:0]       reg_wdata_in,
    input  wire              reg_wr_in,
    input  wire              reg_rd_in,
    output reg  [31:0]       reg_rdata_out,
    // memory command pins
    output wire              mem_clk_out,
    output wire              mem_clk_n_out,
    output reg               cke_out,
    output reg               chip_sel_n_out,
    output reg               row_strobe_n_out,
    output reg               col_strobe_n_out,
    output reg               write_strobe_n_out,
    output reg               bank_select_0_out,
    output reg               bank_select_1_out,
    output reg  [ADDR_W-1:0] addr_out,
    output reg               write_mask_out
);
    // strobe pattern {ras_n, cas_n, we_n} per command code
    function [2:0] strobes;
        input [3:0] code;
        begin
            case (code)
                `DDC_CMD_ACT:     strobes = 3'h3;
                `DDC_CMD_RD:      strobes = 3'h5;
                `DDC_CMD_WR:      strobes = 3'h4;
                `DDC_CMD_BST:     strobes = 3'h6;
                `DDC_CMD_PRE:     strobes = 3'h2;
                `DDC_CMD_REF:     strobes = 3'h1;
                `DDC_CMD_SREF_IN: strobes = 3'h1;
                `DDC_CMD_LOAD:    strobes = 3'h0;
                default:          strobes = 3'h7;
            endcase
        end
    endfunction

    // burst length in data elements from the burst field
    function [3:0] burst_len;
        input [2:0] field;
        begin
            case (field)
                `DDC_BL_4: burst_len = 4'h4;
                `DDC_BL_8: burst_len = 4'h8;
                default:   burst_len = 4'h2;
            endcase
        end
    endfunction

    reg        rst_s1_q;
    reg        rst_n_q;
    wire       fall_tick;
    wire       legal;

    reg        pend_q;
    reg [3:0]  code_q;
    reg [14:0] req_addr_q;
    reg [7:0]  mask_q;
    reg        refused_q;
    reg [12:0] mode_q;
    reg [12:0] ext_q;
    reg [3:0]  open_q;
    reg [3:0]  ap_bank_q;
    reg [2:0]  burst_ck_q;
    reg        rd_no_ap_q;
    reg [1:0]  mrd_q;
    reg [7:0]  dll_cnt_q;
    reg        need_rst_q;
    reg        need_norm_q;
    reg        sref_q;
    reg [7:0]  mask_sh_q;
    reg [3:0]  beats_q;
    reg        wr_arm_q;

    wire [1:0] bank     = {req_addr_q[`DDC_ADDR_BS1_BIT], req_addr_q[`DDC_ADDR_BS0_BIT]};
    wire       dll_on   = !ext_q[`DDC_DLL_DIS_BIT];
    wire       read_ok  = dll_on && (dll_cnt_q == 8'h00) && !need_rst_q;
    wire       burst    = (burst_ck_q != 3'h0);
    wire       launch   = pend_q && fall_tick && (mrd_q == 2'h0);
    wire       issue    = launch && legal;
    wire [3:0] bl       = burst_len(mode_q[2:0]);
    wire       sw_write = reg_wr_in && (reg_addr_in == `DDC_OFF_CMD);
    wire       is_base  = (bank == 2'h0);

    // reset released through two flops
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    ddc_clk_div #(
        .DIV           (CLK_DIV)
    ) u_div (
        .ref_clk_in    (ref_clk_in),
        .rst_n_in      (rst_n_q),
        .clk_en_in     (clk_en_in),
        .mem_clk_out   (mem_clk_out),
        .fall_tick_out (fall_tick)
    );

    assign mem_clk_n_out = !mem_clk_out;

    ddc_cmd_check u_check (
        .code_in       (code_q),
        .addr_in       (req_addr_q),
        .open_banks_in (open_q),
        .burst_in      (burst),
        .bst_ok_in     (burst && rd_no_ap_q),
        .read_ok_in    (read_ok),
        .in_sref_in    (sref_q),
        .legal_out     (legal)
    );

    // software register port
    always @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pend_q        <= 1'b0;
            code_q        <= `DDC_CMD_NOP;
            req_addr_q    <= 15'h0000;
            mask_q        <= `DDC_MASK_RST;
            refused_q     <= 1'b0;
            reg_rdata_out <= 32'h00000000;
        end else if (clk_en_in) begin
            reg_rdata_out <= 32'h00000000;
            if (reg_rd_in) begin
                case (reg_addr_in)
                    `DDC_OFF_CMD:    reg_rdata_out <= {28'h0000000, code_q};
                    `DDC_OFF_ADDR:   reg_rdata_out <= {17'h00000, req_addr_q};
                    `DDC_OFF_MASK:   reg_rdata_out <= {24'h000000, mask_q};
                    `DDC_OFF_STATUS: reg_rdata_out <= {21'h000000, burst, open_q, sref_q,
                                                       need_norm_q, need_rst_q, refused_q,
                                                       (dll_cnt_q != 8'h00), pend_q};
                    `DDC_OFF_MODE:   reg_rdata_out <= {19'h00000, mode_q};
                    `DDC_OFF_EXT:    reg_rdata_out <= {19'h00000, ext_q};
                    default:         reg_rdata_out <= 32'h00000000;
                endcase
            end
            if (reg_wr_in && (reg_addr_in == `DDC_OFF_ADDR) && !pend_q)
                req_addr_q <= reg_wdata_in[14:0];
            if (reg_wr_in && (reg_addr_in == `DDC_OFF_MASK))
                mask_q <= reg_wdata_in[7:0];
            // a command written while one is pending is dropped and flagged
            if (sw_write && !pend_q) begin
                code_q <= reg_wdata_in[3:0];
                pend_q <= 1'b1;
            end else if (launch) begin
                pend_q <= 1'b0;
            end
            // set wins over the write-one clear
            if ((launch && !legal) || (sw_write && pend_q))
                refused_q <= 1'b1;
            else if (reg_wr_in && (reg_addr_in == `DDC_OFF_STATUS) &&
                     reg_wdata_in[`DDC_ST_REFUSED])
                refused_q <= 1'b0;
        end
    end

    // command pins change with the falling edge so they are stable at the rising one
    always @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cke_out            <= 1'b1;
            chip_sel_n_out     <= 1'b1;
            row_strobe_n_out   <= 1'b1;
            col_strobe_n_out   <= 1'b1;
            write_strobe_n_out <= 1'b1;
            bank_select_0_out  <= 1'b0;
            bank_select_1_out  <= 1'b0;
            addr_out           <= {ADDR_W{1'b0}};
        end else if (clk_en_in && fall_tick) begin
            chip_sel_n_out <= 1'b1;
            {row_strobe_n_out, col_strobe_n_out, write_strobe_n_out} <= 3'h7;
            if (issue) begin
                if (code_q == `DDC_CMD_SREF_IN)
                    cke_out <= 1'b0;
                else if (code_q == `DDC_CMD_SREF_OUT)
                    cke_out <= 1'b1;
                chip_sel_n_out <= (strobes(code_q) == 3'h7);
                {row_strobe_n_out, col_strobe_n_out, write_strobe_n_out} <= strobes(code_q);
                bank_select_0_out <= req_addr_q[`DDC_ADDR_BS0_BIT];
                bank_select_1_out <= req_addr_q[`DDC_ADDR_BS1_BIT];
                addr_out          <= req_addr_q[ADDR_W-1:0];
            end
        end
    end

    // bank, burst and mode-register shadow state
    always @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            open_q      <= 4'h0;
            ap_bank_q   <= 4'h0;
            burst_ck_q  <= 3'h0;
            rd_no_ap_q  <= 1'b0;
            mrd_q       <= 2'h0;
            mode_q      <= `DDC_MODE_RST;
            ext_q       <= `DDC_EXT_RST;
            need_rst_q  <= 1'b0;
            need_norm_q <= 1'b0;
            sref_q      <= 1'b0;
        end else if (clk_en_in && fall_tick) begin
            if (mrd_q != 2'h0)
                mrd_q <= mrd_q - 2'h1;
            if (burst_ck_q != 3'h0) begin
                burst_ck_q <= burst_ck_q - 3'h1;
                if (burst_ck_q == 3'h1) begin
                    open_q    <= open_q & ~ap_bank_q;
                    ap_bank_q <= 4'h0;
                end
            end
            if (issue) begin
                case (code_q)
                    `DDC_CMD_ACT: open_q[bank] <= 1'b1;
                    `DDC_CMD_RD, `DDC_CMD_WR: begin
                        burst_ck_q <= bl[3:1];
                        rd_no_ap_q <= (code_q == `DDC_CMD_RD) &&
                                      !req_addr_q[`DDC_PRE_SEL_BIT];
                        ap_bank_q  <= req_addr_q[`DDC_PRE_SEL_BIT] ?
                                      (4'h1 << bank) : 4'h0;
                    end
                    `DDC_CMD_BST: burst_ck_q <= 3'h0;
                    `DDC_CMD_PRE: begin
                        if (req_addr_q[`DDC_PRE_SEL_BIT])
                            open_q <= 4'h0;
                        else
                            open_q[bank] <= 1'b0;
                    end
                    `DDC_CMD_SREF_IN:  sref_q <= 1'b1;
                    `DDC_CMD_SREF_OUT: sref_q <= 1'b0;
                    `DDC_CMD_LOAD: begin
                        mrd_q <= `DDC_TMRD_CK;
                        if (is_base) begin
                            // the reset bit is not kept: it clears itself in the part
                            mode_q <= req_addr_q[12:0] &
                                      ~(13'h0001 << `DDC_DLL_RESET_BIT);
                            need_rst_q  <= need_rst_q &&
                                           !req_addr_q[`DDC_DLL_RESET_BIT];
                            need_norm_q <= req_addr_q[`DDC_DLL_RESET_BIT];
                        end else begin
                            ext_q <= req_addr_q[12:0];
                            if (!req_addr_q[`DDC_DLL_DIS_BIT])
                                need_rst_q <= 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    // dll lock wait, counted in memory clocks with clock enable high
    always @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            dll_cnt_q <= 8'h00;
        end else if (clk_en_in && fall_tick) begin
            if (issue && ((code_q == `DDC_CMD_SREF_OUT) ||
                          ((code_q == `DDC_CMD_LOAD) && is_base &&
                           req_addr_q[`DDC_DLL_RESET_BIT]) ||
                          ((code_q == `DDC_CMD_LOAD) && !is_base &&
                           !req_addr_q[`DDC_DLL_DIS_BIT])))
                dll_cnt_q <= `DDC_DLL_LOCK_CK;
            else if ((dll_cnt_q != 8'h00) && cke_out)
                dll_cnt_q <= dll_cnt_q - 8'h01;
        end
    end

    // write mask: one element per reference cycle, two per memory clock when CLK_DIV is 1
    always @(posedge ref_clk_in or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mask_sh_q      <= 8'h00;
            beats_q        <= 4'h0;
            wr_arm_q       <= 1'b0;
            write_mask_out <= 1'b0;
        end else if (clk_en_in) begin
            wr_arm_q <= issue && (code_q == `DDC_CMD_WR);
            if (wr_arm_q) begin
                mask_sh_q <= mask_q;
                beats_q   <= bl;
            end else if (beats_q != 4'h0) begin
                write_mask_out <= mask_sh_q[0];
                mask_sh_q      <= {1'b0, mask_sh_q[7:1]};
                beats_q        <= beats_q - 4'h1;
            end else begin
                write_mask_out <= 1'b0;
            end
        end
    end
endmodule

//--- ddc_ctrl_monitor.sv
`timescale 1ns/100ps
module ddc_ctrl_monitor #(parameter ADDR_W = 13) (
    // watched ports
    input wire              ref_clk_in, reset_n_in, reg_rd_in, mem_clk_out, mem_clk_n_out,
    input wire              cke_out, chip_sel_n_out, row_strobe_n_out, col_strobe_n_out,
    input wire              write_strobe_n_out, bank_select_0_out, bank_select_1_out,
    input wire [31:0]       reg_rdata_out,
    input wire [ADDR_W-1:0] addr_out
);
    reg  [8:0] dll_cnt_q;
    reg        mclk_q;
    wire       cs   = !chip_sel_n_out;
    wire       ld   = cs && !row_strobe_n_out && !col_strobe_n_out && !write_strobe_n_out;
    wire       base = ld && !bank_select_0_out && !bank_select_1_out;
    wire       rd   = cs && row_strobe_n_out && !col_strobe_n_out && write_strobe_n_out;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    // memory clock rises with cke high since the last dll reset load or self refresh exit
    always @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dll_cnt_q <= 9'h000;
            mclk_q    <= 1'b0;
        end else begin
            mclk_q <= mem_clk_out;
            if ((base && addr_out[8] && $fell(chip_sel_n_out)) || $rose(cke_out))
                dll_cnt_q <= 9'h000;
            else if (mem_clk_out && !mclk_q && cke_out && dll_cnt_q != 9'h1FF)
                dll_cnt_q <= dll_cnt_q + 9'h001;
        end
    end
    a_cmd_on_fall: assert property ($fell(chip_sel_n_out) |-> $fell(mem_clk_out))
        else $error("command not launched at memory clock fall");
    a_cmd_one_clock: assert property ($fell(chip_sel_n_out) |=> cs ##1 !cs)
        else $error("command not held exactly one memory clock");
    a_clk_alternate: assert property (mem_clk_out |=> !mem_clk_out && mem_clk_n_out)
        else $error("memory clock pair wrong");
    a_sref_cke_low: assert property (cs && !row_strobe_n_out && !cke_out |->
        !col_strobe_n_out && write_strobe_n_out) else $error("command with cke low");
    a_load_bank_code: assert property (ld |-> !bank_select_1_out)
        else $error("reserved register select driven");
    a_base_op_mode: assert property (base |-> addr_out[12:7] inside {6'h00, 6'h02})
        else $error("reserved operating mode driven");
    a_base_fields: assert property (base |-> addr_out[2:0] inside {3'h1, 3'h2, 3'h3}
        && addr_out[6:4] inside {3'h2, 3'h6}) else $error("reserved burst or latency");
    a_read_dll_wait: assert property ($fell(chip_sel_n_out) && rd |-> dll_cnt_q >= 9'h0C8)
        else $error("read too soon after dll reset");
    a_rdata_one_cycle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
        else $error("read data outside its cycle");
endmodule

//--- ddc_mem_model.sv
`timescale 1ns/100ps
`include "ddc_regs.vh"
module ddc_mem_model (
    // command pins
    input  wire        mem_clk_in, cke_in, cs_n_in, ras_n_in, cas_n_in, we_n_in,
    input  wire [1:0]  bank_in,
    input  wire [12:0] addr_in,
    // decoded view
    output reg  [3:0]  code_out,
    output int         n_cmd_out,
    output reg  [12:0] mode_out,
    output reg  [12:0] ext_out,
    output reg  [3:0]  open_out
);
    reg [3:0] c;
    initial begin
        n_cmd_out = 0;
        mode_out  = 13'h0000;
        ext_out   = 13'h0001;
        open_out  = 4'h0;
    end
    always @(posedge mem_clk_in) begin
        c = `DDC_CMD_NOP;
        if (!cs_n_in) begin
            case ({ras_n_in, cas_n_in, we_n_in})
                3'b011: c = `DDC_CMD_ACT;
                3'b101: c = `DDC_CMD_RD;
                3'b100: c = `DDC_CMD_WR;
                3'b110: c = `DDC_CMD_BST;
                3'b010: c = `DDC_CMD_PRE;
                3'b001: c = cke_in ? `DDC_CMD_REF : `DDC_CMD_SREF_IN;
                3'b000: c = `DDC_CMD_LOAD;
                default: c = `DDC_CMD_NOP;
            endcase
        end
        if (c == `DDC_CMD_ACT) open_out[bank_in] <= 1'b1;
        if ((c == `DDC_CMD_RD || c == `DDC_CMD_WR) && addr_in[10])
            open_out[bank_in] <= 1'b0;
        if (c == `DDC_CMD_PRE)
            open_out <= addr_in[10] ? 4'h0 : open_out & ~(4'h1 << bank_in);
        if (c == `DDC_CMD_LOAD && bank_in == 2'h0)
            mode_out <= addr_in & 13'h1EFF;
        if (c == `DDC_CMD_LOAD && bank_in == 2'h1) ext_out <= addr_in;
        if (c != `DDC_CMD_NOP) begin
            code_out  <= c;
            n_cmd_out <= n_cmd_out + 1;
        end
    end
endmodule

//--- ddc_regs.vh
`ifndef DDC_REGS_VH
`define DDC_REGS_VH

// software register byte offsets
`define DDC_OFF_CMD        5'h00
`define DDC_OFF_ADDR       5'h04
`define DDC_OFF_MASK       5'h08
`define DDC_OFF_STATUS     5'h0C
`define DDC_OFF_MODE       5'h10
`define DDC_OFF_EXT        5'h14

// command codes written to the command register
`define DDC_CMD_NOP        4'h0
`define DDC_CMD_ACT        4'h1
`define DDC_CMD_RD         4'h2
`define DDC_CMD_WR         4'h3
`define DDC_CMD_BST        4'h4
`define DDC_CMD_PRE        4'h5
`define DDC_CMD_REF        4'h6
`define DDC_CMD_SREF_IN    4'h7
`define DDC_CMD_SREF_OUT   4'h8
`define DDC_CMD_LOAD       4'h9

// address register fields
`define DDC_ADDR_BS0_BIT   13
`define DDC_ADDR_BS1_BIT   14
`define DDC_PRE_SEL_BIT    10
`define DDC_DLL_RESET_BIT  8
`define DDC_DLL_DIS_BIT    0

// status register fields
`define DDC_ST_BUSY        0
`define DDC_ST_DLL_WAIT    1
`define DDC_ST_REFUSED     2
`define DDC_ST_NEED_RST    3
`define DDC_ST_NEED_NORM   4
`define DDC_ST_SREF        5
`define DDC_ST_OPEN_LO     6
`define DDC_ST_BURST       10

// base mode field values
`define DDC_OPMODE_NORMAL  6'h00
`define DDC_OPMODE_DLLRST  6'h02
`define DDC_BL_2           3'h1
`define DDC_BL_4           3'h2
`define DDC_BL_8           3'h3
`define DDC_CL_2           3'h2
`define DDC_CL_2P5         3'h6

// reset values
`define DDC_MODE_RST       13'h0000
`define DDC_EXT_RST        13'h0001
`define DDC_MASK_RST       8'h00

// timing, in memory clock cycles
`define DDC_DLL_LOCK_CK    8'hC8
`define DDC_TMRD_CK        2'h2

`endif

//--- testbench.sv
`timescale 1ns/100ps
`include "ddc_regs.vh"
module testbench;
    reg         clk = 0, rst_n = 0, clk_en = 1, wr = 0, rd = 0, rd_chk = 0, chk_q = 0;
    reg  [4:0]  ra = 0;
    reg  [31:0] wd = 0, last_rd, r, seed = 32'h425CC00B, rq[$], mq[$];
    reg         wq[$];
    reg  [2:0]  wm_n = 0;
    reg  [3:0]  cq[$];
    wire [31:0] rdata;
    wire        mck, cke, csn, rasn, casn, wen, b0, b1, wm;
    wire [12:0] ma, m_mode, m_ext;
    wire [3:0]  m_code, m_open;
    int         m_n, mn_q = 0, n_mismatch = 0, samples_checked = 0;
    ddc_ctrl DUT (.ref_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(clk_en), .reg_addr_in(ra),
        .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .mem_clk_out(mck), .mem_clk_n_out(), .cke_out(cke), .chip_sel_n_out(csn),
        .row_strobe_n_out(rasn), .col_strobe_n_out(casn), .write_strobe_n_out(wen),
        .bank_select_0_out(b0), .bank_select_1_out(b1), .addr_out(ma), .write_mask_out(wm));
    ddc_mem_model u_mem (.mem_clk_in(mck), .cke_in(cke), .cs_n_in(csn), .ras_n_in(rasn),
        .cas_n_in(casn), .we_n_in(wen), .bank_in({b1, b0}), .addr_in(ma), .code_out(m_code),
        .n_cmd_out(m_n), .mode_out(m_mode), .ext_out(m_ext), .open_out(m_open));
    initial forever #10 clk = ~clk;
    function automatic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic cmp(input string n, input [31:0] e, input [31:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // result watchers: read data, and commands decoded by the memory model
    always @(posedge clk) begin
        if (chk_q) cmp("reg_rdata", rq.pop_front(), rdata & mq.pop_front());
        chk_q <= rd & rd_chk;
    end
    always @(m_n) #1 if (m_n > 0) cmp("mem_cmd", cq.size() ? cq.pop_front() : 4'hF, m_code);
    // mask elements start two ref cycles after a decoded write, four at the loaded length
    always @(posedge clk) begin
        if (wm_n != 0) cmp("write_mask", wq.pop_front(), wm);
        if (m_n != mn_q && m_code == `DDC_CMD_WR)
            wm_n <= 3'h4;
        else if (wm_n != 0)
            wm_n <= wm_n - 3'h1;
        mn_q <= m_n;
    end
    task automatic wr_reg(input [4:0] a, input [31:0] d);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input [4:0] a, input c, input [31:0] e, input [31:0] m);
        ra <= a;
        rd <= 1'b1;
        rd_chk <= c;
        if (c) rq.push_back(e & m);
        if (c) mq.push_back(m);
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk) last_rd = rdata;
        @(posedge clk);
    endtask
    task automatic issue(input [3:0] c, input [14:0] a, input ok);
        int n;
        wr_reg(`DDC_OFF_ADDR, {17'h0, a});
        if (ok && c != `DDC_CMD_SREF_OUT && c != `DDC_CMD_NOP) cq.push_back(c);
        wr_reg(`DDC_OFF_CMD, {28'h0, c});
        for (n = 0; n < 40; n++) begin
            rd_reg(`DDC_OFF_STATUS, 0, 0, 0);
            if (last_rd[0] === 1'b0) break;
        end
        cmp("busy", 0, last_rd[0]);
        rd_reg(`DDC_OFF_STATUS, 1, ok ? 32'h0 : 32'h4, 32'h4);
        if (!ok) wr_reg(`DDC_OFF_STATUS, 32'h4);
    endtask
    initial begin
        #200000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(`DDC_OFF_MODE, 1, 32'h0, 32'hFFFFFFFF);
        rd_reg(`DDC_OFF_EXT, 1, 32'h1, 32'hFFFFFFFF);
        rd_reg(5'h18, 1, 32'h0, 32'hFFFFFFFF);
        issue(`DDC_CMD_NOP, 15'h0000, 1);
        issue(`DDC_CMD_LOAD, 15'h2000, 1);
        rd_reg(`DDC_OFF_EXT, 1, 32'h0, 32'hFFFFFFFF);
        cmp("ext", 32'h0, m_ext);
        issue(`DDC_CMD_LOAD, 15'h6000, 0);
        issue(`DDC_CMD_LOAD, 15'h0222, 0);
        issue(`DDC_CMD_LOAD, 15'h0122, 1);
        cmp("mode", 32'h22, m_mode);
        issue(`DDC_CMD_LOAD, 15'h0022, 1);
        rd_reg(`DDC_OFF_MODE, 1, 32'h22, 32'hFFFFFFFF);
        r = xs();
        issue(`DDC_CMD_ACT, r[14:0], 1);
        issue(`DDC_CMD_ACT, r[14:0], 0);
        issue(`DDC_CMD_LOAD, 15'h0022, 0);
        issue(`DDC_CMD_RD, {r[14:13], 13'h0004}, 0);
        repeat (420) @(posedge clk);
        issue(`DDC_CMD_BST, 15'h0000, 0);
        issue(`DDC_CMD_RD, {r[14:13], 3'h0, r[9:0]}, 1);
        wr_reg(`DDC_OFF_MASK, {24'h0, r[31:24]});
        rd_reg(`DDC_OFF_MASK, 1, {24'h0, r[31:24]}, 32'hFF);
        for (int k = 0; k < 4; k++)
            wq.push_back(r[24 + k]);
        issue(`DDC_CMD_WR, {r[14:13], 3'h1, r[9:0]}, 1);
        issue(`DDC_CMD_ACT, r[14:0], 1);
        issue(`DDC_CMD_PRE, 15'h0400, 1);
        cmp("open_banks", 0, m_open);
        issue(`DDC_CMD_REF, 15'h0000, 1);
        issue(`DDC_CMD_SREF_IN, 15'h0000, 1);
        cmp("cke", 0, cke);
        issue(`DDC_CMD_ACT, r[14:0], 0);
        issue(`DDC_CMD_SREF_OUT, 15'h0000, 1);
        cmp("cke", 1, cke);
        issue(4'hF, 15'h0000, 0);
        cmp("mask_left", 0, wq.size());
        cmp("cmd_left", 0, cq.size());
        tally_and_finish();
    end
endmodule
bind ddc_ctrl ddc_ctrl_monitor #(.ADDR_W(ADDR_W)) u_mon (.ref_clk_in, .reset_n_in, .reg_rd_in,
    .reg_rdata_out, .mem_clk_out, .mem_clk_n_out, .cke_out, .chip_sel_n_out, .row_strobe_n_out,
    .col_strobe_n_out, .write_strobe_n_out, .bank_select_0_out, .bank_select_1_out, .addr_out);
